// >>> ccp_defines.vh
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets on the APB
`define UNIT_STRIDE 8'h10
`define OFS_MODE_CTRL 8'h00
`define OFS_DATA_LOW 8'h04
`define OFS_DATA_HIGH 8'h08
`define OFS_T3_CTRL 8'h30
`define OFS_T3_COUNT 8'h34
`define OFS_FLAGS 8'h38

////////////////////////////////////////////////////////////////////////
// register identifiers returned by the address decoder
`define ID_T3_CTRL 4'h9
`define ID_T3_COUNT 4'hA
`define ID_FLAGS 4'hB
`define ID_NONE 4'hF

////////////////////////////////////////////////////////////////////////
// reset values and field positions
`define CTRL_RESET 8'h00
`define CTRL_IMPL_MASK 8'h3F
`define T3_CTRL_RESET 8'h00
`define DATA_RESET 8'h00
`define MODE_MSB 3
`define MODE_LSB 0
`define DUTY_MSB 5
`define DUTY_LSB 4
`define T3_ON_BIT 0
`define T3_CS_BIT 1
`define T3_SEL_LO_BIT 3
`define T3_PS_MSB 5
`define T3_PS_LSB 4
`define T3_SEL_HI_BIT 6
`define FLAG_T3_BIT 3
`define T3_COUNT_MAX 16'hFFFF

////////////////////////////////////////////////////////////////////////
// unit mode codes
`define MODE_OFF 4'h0
`define MODE_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_4 4'h6
`define MODE_CAP_16 4'h7
`define MODE_SET_HIGH 4'h8
`define MODE_SET_LOW 4'h9
`define MODE_SOFT_INT 4'hA
`define MODE_SPECIAL 4'hB

// capture prescaler terminal counts (rising edges minus one)
`define CAP_TERM_4 4'h3
`define CAP_TERM_16 4'hF

////////////////////////////////////////////////////////////////////////
// timer select codes
`define SEL_ALL_FIRST 2'h0
`define SEL_U1_FIRST 2'h1
`define SEL_U3_THIRD 2'h2
`define SEL_ALL_THIRD 2'h3

`endif

// >>> ccp_unit.v
`timescale 1ns/1ps
`include "ccp_defines.vh"

module ccp_unit #(
    parameter HAS_TRIGGER = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [3:0] mode,
    input wire [1:0] duty_bits,
    input wire [15:0] data,
    input wire [15:0] timer_count,
    input wire [9:0] pwm_count,
    input wire pwm_period,
    input wire pin_in,
    output reg pin_out,
    output wire pin_oe,
    output reg capture,
    output reg [15:0] capture_value,
    output reg flag_set,
    output reg trigger
);

////////////////////////////////////////////////////////////////////////
// pin synchroniser: a change counts once stages two and three agree
reg sync1;
reg sync2;
reg sync3;
reg level;
wire settled = (sync2 == sync3) && (sync3 != level);
wire rise = settled & sync3;
wire fall = settled & ~sync3;

reg [3:0] mode_d;
reg [3:0] pre;
reg match_d;
reg [9:0] duty_latch;

wire is_capture = (mode[3:2] == 2'b01);
wire is_pwm = (mode[3:2] == 2'b11);
wire is_compare = (mode == `MODE_TOGGLE) || (mode[3:2] == 2'b10);
wire match = (timer_count == data);
// edge of the match only, so a stalled timer flags once
wire match_evt = match & ~match_d & is_compare;
wire entered = (mode != mode_d);
reg cap_evt;

always @* begin
    case (mode)
        `MODE_CAP_FALL: cap_evt = fall;
        `MODE_CAP_RISE: cap_evt = rise;
        `MODE_CAP_4: cap_evt = rise && (pre == `CAP_TERM_4);
        `MODE_CAP_16: cap_evt = rise && (pre == `CAP_TERM_16);
        default: cap_evt = 1'b0;
    endcase
end

// pin owned by the unit only when it drives it; 1010 and 1011 leave it
assign pin_oe = is_pwm || (mode == `MODE_TOGGLE) ||
    (mode == `MODE_SET_HIGH) || (mode == `MODE_SET_LOW);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1 <= 1'b0;
        sync2 <= 1'b0;
        sync3 <= 1'b0;
        level <= 1'b0;
        mode_d <= `MODE_OFF;
        pre <= 4'h0;
        match_d <= 1'b0;
        duty_latch <= 10'h000;
        pin_out <= 1'b0;
        capture <= 1'b0;
        capture_value <= 16'h0000;
        flag_set <= 1'b0;
        trigger <= 1'b0;
    end else begin
        sync1 <= pin_in;
        sync2 <= sync1;
        sync3 <= sync2;
        if (sync2 == sync3) begin
            level <= sync3;
        end
        mode_d <= mode;
        match_d <= match;
        capture <= cap_evt;
        capture_value <= timer_count;
        flag_set <= cap_evt | match_evt;
        trigger <= match_evt && (mode == `MODE_SPECIAL) &&
            (HAS_TRIGGER != 0);
        if (!is_capture || cap_evt) begin
            pre <= 4'h0;
        end else if (rise) begin
            pre <= pre + 4'h1;
        end
        if (mode == `MODE_OFF) begin
            pin_out <= 1'b0;
            duty_latch <= 10'h000;
        end else if (is_pwm) begin
            if (pwm_period) begin
                pin_out <= 1'b1;
                duty_latch <= {data[7:0], duty_bits};
            end else if (pwm_count == duty_latch) begin
                pin_out <= 1'b0;
            end
        end else if (entered && mode == `MODE_SET_HIGH) begin
            pin_out <= 1'b0;
        end else if (entered && mode == `MODE_SET_LOW) begin
            pin_out <= 1'b1;
        end else if (match_evt) begin
            case (mode)
                `MODE_TOGGLE: pin_out <= ~pin_out;
                `MODE_SET_HIGH: pin_out <= 1'b1;
                `MODE_SET_LOW: pin_out <= 1'b0;
                default: pin_out <= pin_out;
            endcase
        end
    end
end

endmodule

// >>> ccp_block.v
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ccp_defines.vh"

module ccp_block #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] first_timer_count,
    output wire first_timer_reset,
    input wire [7:0] second_timer_count,
    input wire [1:0] second_timer_fine,
    input wire second_timer_period_match,
    input wire third_timer_ext_clk,
    output reg [15:0] third_timer_count,
    input wire adc_enabled,
    output wire adc_start,
    input wire unit2_pin_select,
    input wire unit2_alt_select_b,
    input wire unit1_pin_in,
    output wire unit1_pin_out,
    output wire unit1_pin_oe,
    input wire unit2_default_pin_in,
    output wire unit2_default_pin_out,
    output wire unit2_default_pin_oe,
    input wire unit2_alternate_pin_a_in,
    output wire unit2_alternate_pin_a_out,
    output wire unit2_alternate_pin_a_oe,
    input wire unit2_alternate_pin_b_in,
    output wire unit2_alternate_pin_b_out,
    output wire unit2_alternate_pin_b_oe,
    input wire unit3_pin_in,
    output wire unit3_pin_out,
    output wire unit3_pin_oe,
    output wire [2:0] unit_interrupt_flag,
    output wire third_timer_overflow_flag
);

////////////////////////////////////////////////////////////////////////
// decoding shared by the write and read paths

function [3:0] reg_id;
    input [ADDR_W-1:0] a;
    integer k;
    reg [7:0] base;
    begin
        reg_id = `ID_NONE;
        for (k = 0; k < 3; k = k + 1) begin
            base = k[3:0] * `UNIT_STRIDE;
            if (a == base + `OFS_MODE_CTRL)
                reg_id = k[3:0] * 4'h3;
            if (a == base + `OFS_DATA_LOW)
                reg_id = k[3:0] * 4'h3 + 4'h1;
            if (a == base + `OFS_DATA_HIGH)
                reg_id = k[3:0] * 4'h3 + 4'h2;
        end
        if (a == `OFS_T3_CTRL)
            reg_id = `ID_T3_CTRL;
        if (a == `OFS_T3_COUNT)
            reg_id = `ID_T3_COUNT;
        if (a == `OFS_FLAGS)
            reg_id = `ID_FLAGS;
    end
endfunction

// true when a unit times its capture/compare off the third timer
function on_third;
    input [1:0] sel;
    input integer unit;
    begin
        case (sel)
            `SEL_ALL_FIRST: on_third = 1'b0;
            `SEL_U1_FIRST: on_third = (unit != 0);
            `SEL_U3_THIRD: on_third = (unit == 2);
            `SEL_ALL_THIRD: on_third = 1'b1;
            default: on_third = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// APB slave: zero wait states, error on unmapped offsets

wire [3:0] id = reg_id(paddr);
wire setup = psel & ~penable;
wire access = psel & penable;
wire wr = access & pwrite & (id != `ID_NONE);

assign pready = 1'b1;
assign pslverr = access & (id == `ID_NONE);

reg [7:0] mode_ctrl [0:2];
reg [7:0] data_low [0:2];
reg [7:0] data_high [0:2];
reg [7:0] t3_ctrl;
reg [3:0] flags;

wire [1:0] sel = {t3_ctrl[`T3_SEL_HI_BIT], t3_ctrl[`T3_SEL_LO_BIT]};

////////////////////////////////////////////////////////////////////////
// the three units

wire [2:0] unit_pin_in;
wire [2:0] unit_pin_out;
wire [2:0] unit_pin_oe;
wire [2:0] capture;
wire [47:0] capture_value;
wire [2:0] flag_set;
wire [2:0] trigger;
wire [2:0] uses_third;

// unit 2 sees only the pin it is multiplexed onto
assign unit_pin_in[0] = unit1_pin_in;
assign unit_pin_in[1] = unit2_pin_select ? unit2_default_pin_in :
    (unit2_alt_select_b ? unit2_alternate_pin_b_in :
    unit2_alternate_pin_a_in);
assign unit_pin_in[2] = unit3_pin_in;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : units
        assign uses_third[g] = on_third(sel, g);
        ccp_unit #(
            .HAS_TRIGGER(g < 2 ? 1 : 0)
        ) unit (
            .pclk(pclk),
            .presetn(presetn),
            .mode(mode_ctrl[g][`MODE_MSB:`MODE_LSB]),
            .duty_bits(mode_ctrl[g][`DUTY_MSB:`DUTY_LSB]),
            .data({data_high[g], data_low[g]}),
            .timer_count(uses_third[g] ? third_timer_count :
                first_timer_count),
            .pwm_count({second_timer_count, second_timer_fine}),
            .pwm_period(second_timer_period_match),
            .pin_in(unit_pin_in[g]),
            .pin_out(unit_pin_out[g]),
            .pin_oe(unit_pin_oe[g]),
            .capture(capture[g]),
            .capture_value(capture_value[16*g+15:16*g]),
            .flag_set(flag_set[g]),
            .trigger(trigger[g])
        );
    end
endgenerate

assign unit1_pin_out = unit_pin_out[0];
assign unit1_pin_oe = unit_pin_oe[0];
assign unit2_default_pin_out = unit_pin_out[1];
assign unit2_default_pin_oe = unit_pin_oe[1] & unit2_pin_select;
assign unit2_alternate_pin_a_out = unit_pin_out[1];
assign unit2_alternate_pin_a_oe = unit_pin_oe[1] & ~unit2_pin_select &
    ~unit2_alt_select_b;
assign unit2_alternate_pin_b_out = unit_pin_out[1];
assign unit2_alternate_pin_b_oe = unit_pin_oe[1] & ~unit2_pin_select &
    unit2_alt_select_b;
assign unit3_pin_out = unit_pin_out[2];
assign unit3_pin_oe = unit_pin_oe[2];

////////////////////////////////////////////////////////////////////////
// special event routing

wire t3_reset = |(trigger & uses_third);
assign first_timer_reset = |(trigger & ~uses_third);
// only unit 2 may start a conversion, and only with converter enabled
assign adc_start = trigger[1] & adc_enabled;

////////////////////////////////////////////////////////////////////////
// register file

integer i;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (i = 0; i < 3; i = i + 1) begin
            mode_ctrl[i] <= `CTRL_RESET;
            data_low[i] <= `DATA_RESET;
            data_high[i] <= `DATA_RESET;
        end
        t3_ctrl <= `T3_CTRL_RESET;
    end else begin
        for (i = 0; i < 3; i = i + 1) begin
            if (wr && id == i * 3)
                mode_ctrl[i] <= pwdata[7:0] & `CTRL_IMPL_MASK;
            // software write wins over a capture landing the same cycle
            if (wr && id == i * 3 + 1)
                data_low[i] <= pwdata[7:0];
            else if (capture[i])
                data_low[i] <= capture_value[16*i+:8];
            if (wr && id == i * 3 + 2)
                data_high[i] <= pwdata[7:0];
            else if (capture[i])
                data_high[i] <= capture_value[16*i+8+:8];
        end
        if (wr && id == `ID_T3_CTRL)
            t3_ctrl <= pwdata[7:0];
    end
end

////////////////////////////////////////////////////////////////////////
// third timer: internal tick or synchronised external edge, prescaled

reg ext1;
reg ext2;
reg ext3;
reg ext_level;
reg [2:0] t3_pre;
wire [1:0] t3_ps = t3_ctrl[`T3_PS_MSB:`T3_PS_LSB];
wire [2:0] ps_mask = {t3_ps == 2'b11, t3_ps[1], t3_ps != 2'b00};
wire ext_rise = (ext2 == ext3) & ext3 & ~ext_level;
// external input is always resynchronised, never counted raw
wire t3_tick = t3_ctrl[`T3_ON_BIT] &
    (t3_ctrl[`T3_CS_BIT] ? ext_rise : 1'b1);
wire t3_inc = t3_tick & ((t3_pre & ps_mask) == ps_mask);
wire t3_write = wr && (id == `ID_T3_COUNT);
wire t3_wrap = t3_inc & (third_timer_count == `T3_COUNT_MAX) &
    ~t3_write & ~t3_reset;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ext1 <= 1'b0;
        ext2 <= 1'b0;
        ext3 <= 1'b0;
        ext_level <= 1'b0;
        t3_pre <= 3'h0;
        third_timer_count <= 16'h0000;
    end else begin
        ext1 <= third_timer_ext_clk;
        ext2 <= ext1;
        ext3 <= ext2;
        if (ext2 == ext3)
            ext_level <= ext3;
        if (t3_write) begin
            third_timer_count <= pwdata[15:0];
            t3_pre <= 3'h0;
        end else if (t3_reset) begin
            // clearing is not a wrap, so no overflow flag follows
            third_timer_count <= 16'h0000;
            t3_pre <= 3'h0;
        end else if (t3_tick) begin
            t3_pre <= t3_inc ? 3'h0 : t3_pre + 3'h1;
            if (t3_inc)
                third_timer_count <= third_timer_count + 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// flags: write one to clear, a same-cycle set wins

wire [3:0] flag_clr = (wr && id == `ID_FLAGS) ? pwdata[3:0] : 4'h0;
wire [3:0] flag_new = {t3_wrap, flag_set};

always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        flags <= 4'h0;
    else
        flags <= (flags & ~flag_clr) | flag_new;
end

assign unit_interrupt_flag = flags[2:0];
assign third_timer_overflow_flag = flags[`FLAG_T3_BIT];

////////////////////////////////////////////////////////////////////////
// read data: captured in the setup cycle, held through access

reg [31:0] rd_mux;

always @* begin
    rd_mux = 32'h0000_0000;
    case (id)
        4'h0: rd_mux = {24'h000000, mode_ctrl[0]};
        4'h1: rd_mux = {24'h000000, data_low[0]};
        4'h2: rd_mux = {24'h000000, data_high[0]};
        4'h3: rd_mux = {24'h000000, mode_ctrl[1]};
        4'h4: rd_mux = {24'h000000, data_low[1]};
        4'h5: rd_mux = {24'h000000, data_high[1]};
        4'h6: rd_mux = {24'h000000, mode_ctrl[2]};
        4'h7: rd_mux = {24'h000000, data_low[2]};
        4'h8: rd_mux = {24'h000000, data_high[2]};
        `ID_T3_CTRL: rd_mux = {24'h000000, t3_ctrl};
        `ID_T3_COUNT: rd_mux = {16'h0000, third_timer_count};
        `ID_FLAGS: rd_mux = {28'h0000000, flags};
        default: rd_mux = 32'h0000_0000;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
        prdata <= rd_mux;
end

endmodule

// >>> ccp_block_chk.sv
`timescale 1ns/1ps
module ccp_block_chk #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire first_timer_reset,
    input wire [15:0] third_timer_count,
    input wire adc_enabled,
    input wire adc_start,
    input wire unit2_pin_select,
    input wire unit2_default_pin_oe,
    input wire unit2_alternate_pin_a_oe,
    input wire unit2_alternate_pin_b_oe,
    input wire [2:0] unit_interrupt_flag,
    input wire third_timer_overflow_flag
);
    wire [7:0] a = paddr[7:0];
    wire acc = psel && penable;
    wire t3_wr = acc && pwrite && a == 8'h34;
    wire mapped = a[7:6] == 2'h0 && a[1:0] == 2'h0 && a[3:2] != 2'h3;
    reg [1:0] sel_q;
    reg flag_wr_q;
    ////////////////////////////////////////////////////////////////////
    // shadow of the timer select bits: tells which timer unit 2 uses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 2'h0;
            flag_wr_q <= 1'b0;
        end else begin
            if (acc && pwrite && a == 8'h30)
                sel_q <= {pwdata[6], pwdata[3]};
            flag_wr_q <= acc && pwrite && a == 8'h38;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unmapped_error: assert property (acc |-> pslverr == !mapped)
        else $error("slave error does not follow the address map");
    a_ctrl_upper_zero: assert property (
        acc && !pwrite && mapped && a[5:2] inside {4'h0, 4'h4, 4'h8}
        |-> prdata[31:6] == 26'h0000000)
        else $error("control read shows unimplemented bits");
    a_adc_needs_enable: assert property (adc_start |-> adc_enabled)
        else $error("conversion started while converter disabled");
    a_event_clears_t3: assert property (
        adc_start && sel_q[0] && !t3_wr |=> third_timer_count == 16'h0000)
        else $error("third timer not cleared by unit 2 event");
    a_write_beats_reset: assert property (
        t3_wr |=> third_timer_count == $past(pwdata[15:0]))
        else $error("third timer count write lost");
    a_event_no_ovf: assert property (
        adc_start && sel_q[0] && !third_timer_overflow_flag
        |=> !third_timer_overflow_flag)
        else $error("special event set the overflow flag");
    a_flag_sticky: assert property (
        !flag_wr_q |-> ($past(unit_interrupt_flag) & ~unit_interrupt_flag)
        == 3'h0)
        else $error("unit flag dropped without a clear");
    a_first_reset_routed: assert property (
        first_timer_reset |-> sel_q != 2'h3)
        else $error("first timer reset while no unit uses it");
    a_alt_pin_quiet: assert property (
        unit2_pin_select && $past(unit2_pin_select)
        |-> !unit2_alternate_pin_a_oe && !unit2_alternate_pin_b_oe)
        else $error("alternate pin driven while default selected");
    a_default_pin_quiet: assert property (
        !unit2_pin_select && !$past(unit2_pin_select)
        |-> !unit2_default_pin_oe)
        else $error("default pin driven while alternate selected");
endmodule
bind ccp_block ccp_block_chk #(.ADDR_W(ADDR_W)) ccp_block_chk_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pslverr, .first_timer_reset, .third_timer_count, .adc_enabled,
    .adc_start, .unit2_pin_select, .unit2_default_pin_oe,
    .unit2_alternate_pin_a_oe, .unit2_alternate_pin_b_oe,
    .unit_interrupt_flag, .third_timer_overflow_flag);

// >>> ccp_far_model.sv
`timescale 1ns/1ps
module ccp_far_model #(
    parameter PWM_TOP = 10'h0FF
) (
    input wire pclk,
    input wire presetn,
    input wire first_timer_reset,
    input wire adc_start,
    input wire ft_clear,
    output logic [15:0] first_timer_count,
    output wire [7:0] second_timer_count,
    output wire [1:0] second_timer_fine,
    output logic second_timer_period_match,
    output logic [7:0] ft_reset_count,
    output logic [7:0] adc_count
);
    logic [9:0] pwm_base;
    assign {second_timer_count, second_timer_fine} = pwm_base;
    // first timer free runs; the block's special event reloads it at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_timer_count <= 16'h0000;
            pwm_base <= 10'h000;
            second_timer_period_match <= 1'b0;
            ft_reset_count <= 8'h00;
            adc_count <= 8'h00;
        end else begin
            if (ft_clear || first_timer_reset)
                first_timer_count <= 16'h0000;
            else
                first_timer_count <= first_timer_count + 16'h0001;
            pwm_base <= (pwm_base == PWM_TOP) ? 10'h000 : pwm_base + 10'h001;
            second_timer_period_match <= pwm_base == PWM_TOP;
            ft_reset_count <= ft_reset_count + {7'h00, first_timer_reset};
            adc_count <= adc_count + {7'h00, adc_start};
        end
    end
endmodule

// >>> ccp_block_test.sv
`timescale 1ns/1ps
module ccp_block_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic adc_enabled = 0, unit2_pin_select = 1, unit2_alt_select_b = 0;
    logic unit1_pin_in = 0, unit3_pin_in = 0, ft_clear = 0;
    wire [31:0] prdata;
    wire pready, pslverr, first_timer_reset, second_timer_period_match;
    wire adc_start, third_timer_overflow_flag;
    wire [15:0] first_timer_count, third_timer_count;
    wire [7:0] second_timer_count, ft_reset_count, adc_count;
    wire [1:0] second_timer_fine;
    wire unit1_pin_out, unit1_pin_oe, unit3_pin_out, unit3_pin_oe;
    wire unit2_default_pin_out, unit2_default_pin_oe;
    wire unit2_alternate_pin_a_out, unit2_alternate_pin_a_oe;
    wire unit2_alternate_pin_b_out, unit2_alternate_pin_b_oe;
    wire [2:0] unit_interrupt_flag;
    int mismatches = 0, check_count = 0;
    logic [31:0] rd;
    logic err;
    logic [15:0] v;
    logic [3:0] cmp_mode [0:3] = '{4'h2, 4'h8, 4'h9, 4'hA};
    logic [1:0] cmp_pin [0:3] = '{2'h1, 2'h1, 2'h2, 2'h0};
    int caps [0:3] = '{1, 1, 4, 16};

    always #25 pclk = ~pclk;

    ccp_block ccp_block_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .first_timer_count,
        .first_timer_reset, .second_timer_count, .second_timer_fine,
        .second_timer_period_match, .third_timer_ext_clk(1'b0),
        .third_timer_count, .adc_enabled, .adc_start, .unit2_pin_select,
        .unit2_alt_select_b, .unit1_pin_in, .unit1_pin_out, .unit1_pin_oe,
        .unit2_default_pin_in(1'b0), .unit2_default_pin_out,
        .unit2_default_pin_oe, .unit2_alternate_pin_a_in(1'b0),
        .unit2_alternate_pin_a_out, .unit2_alternate_pin_a_oe,
        .unit2_alternate_pin_b_in(1'b0), .unit2_alternate_pin_b_out,
        .unit2_alternate_pin_b_oe, .unit3_pin_in, .unit3_pin_out,
        .unit3_pin_oe, .unit_interrupt_flag, .third_timer_overflow_flag);
    ccp_far_model ccp_far_model_i (.pclk, .presetn, .first_timer_reset,
        .adc_start, .ft_clear, .first_timer_count, .second_timer_count,
        .second_timer_fine, .second_timer_period_match, .ft_reset_count,
        .adc_count);

    ////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic give_up(input string what);
        mismatches++;
        $display("timeout waiting for %s", what);
        results;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            give_up("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
            input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wait_flag(input int u);
        int n;
        n = 0;
        while (unit_interrupt_flag[u] !== 1'b1 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 500)
            give_up("unit flag");
    endtask

    task automatic clear_first;
        ft_clear <= 1'b1;
        step(1);
        ft_clear <= 1'b0;
    endtask

    task automatic pulse;
        unit1_pin_in <= 1'b1;
        step(6);
        unit1_pin_in <= 1'b0;
        step(6);
    endtask

    // one unit in special event mode under one timer select setting
    task automatic route(input int s, input int u);
        logic [7:0] base, f0, a0;
        logic [15:0] d;
        logic third;
        base = 8'(16 * (u - 1));
        d = 16'h0028 + 16'($urandom % 40);
        third = (u == 3) ? (s != 0) : (u == 2) ? s[0] : (s == 3);
        for (int k = 0; k < 3; k++)
            apb(1'b1, 8'(16 * k), 32'h0);
        apb(1'b1, 8'h30, 32'(s[1] << 6 | s[0] << 3 | 1));
        apb(1'b1, base + 8'h04, 32'(d[7:0]));
        apb(1'b1, base + 8'h08, 32'h0);
        unit2_pin_select <= 1'($urandom);
        unit2_alt_select_b <= 1'($urandom);
        adc_enabled <= 1'($urandom);
        apb(1'b1, 8'h34, 32'h0);
        clear_first;
        apb(1'b1, 8'h38, 32'h7);
        f0 = ft_reset_count;
        a0 = adc_count;
        apb(1'b1, base, 32'hB);
        wait_flag(u - 1);
        chk("first reset", !third && u != 3, ft_reset_count != f0);
        chk("adc start", u == 2 && adc_enabled, adc_count != a0);
        apb(1'b0, 8'h34, 32'h0);
        chk("third reset", third && u != 3, rd < d);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        step(100000);
        give_up("end of run");
    end

    initial begin
        void'($urandom(65140));
        step(6);
        presetn <= 1'b1;
        for (int u = 0; u < 3; u++) begin
            v = 16'($urandom);
            rdc(8'(16 * u), 32'h0, "control reset");
            apb(1'b1, 8'(16 * u), 32'hFF);
            rdc(8'(16 * u), 32'h3F, "control bits");
            apb(1'b1, 8'(16 * u), 32'h0);
            apb(1'b1, 8'(16 * u + 4), 32'(v[7:0]));
            apb(1'b1, 8'(16 * u + 8), 32'(v[15:8]));
            rdc(8'(16 * u + 4), 32'(v[7:0]), "data low");
            rdc(8'(16 * u + 8), 32'(v[15:8]), "data high");
        end
        rdc(8'h30, 32'h0, "timer control reset");
        apb(1'b1, 8'h3C, 32'hFF);
        chk("unmapped error", 32'h1, err);
        rdc(8'h0C, 32'h0, "unmapped read");
        $display("register test done");
        for (int s = 0; s < 4; s++)
            for (int u = 1; u < 4; u++)
                route(s, u);
        $display("timer routing test done");
        apb(1'b1, 8'h30, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h20, 32'h0);
            step(2);
            chk("pin off", 32'h0, {unit3_pin_out, unit3_pin_oe});
            apb(1'b1, 8'h24, 32'h3C);
            apb(1'b1, 8'h28, 32'h0);
            clear_first;
            apb(1'b1, 8'h38, 32'h7);
            apb(1'b1, 8'h20, 32'(cmp_mode[i]));
            step(2);
            chk("pin enable", i != 3, unit3_pin_oe);
            if (i != 3)
                chk("pin start", cmp_pin[i][1], unit3_pin_out);
            wait_flag(2);
            step(2);
            if (i != 3)
                chk("pin match", cmp_pin[i][0], unit3_pin_out);
        end
        apb(1'b1, 8'h20, 32'h3C);
        step(2);
        chk("pwm enable", 32'h1, unit3_pin_oe);
        step(260);
        v = 16'h0000;
        repeat (256) begin
            step(1);
            v += 16'(unit3_pin_out);
        end
        chk("pwm duty", 32'h0F3, v);
        apb(1'b1, 8'h34, 32'hFFF0);
        step(24);
        chk("overflow flag", 32'h1, third_timer_overflow_flag);
        $display("compare test done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h00, 32'(4 + m));
            apb(1'b1, 8'h38, 32'h7);
            repeat (caps[m] - 1) pulse;
            step(8);
            chk("capture early", 32'h0, unit_interrupt_flag[0]);
            pulse;
            step(8);
            chk("capture due", 32'h1, unit_interrupt_flag[0]);
        end
        $display("capture test done");
        results;
    end
endmodule
